//--- design/spi_control_config.sv
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// R1: Master with clock release set stops the clock; clock pin goes to general I/O.
// R2: Data-out release set leaves the serial output pin undriven by the port.
// R3: Word-width select 1 shifts sixteen bits per transfer.
// R4: Word-width select 0 shifts eight bits per transfer.
// R5: Master samples input at end of output time if phase 1, middle if 0.
// R6: Software keeps sample phase cleared in slave role.
// R7: Edge bit 1 changes output on active-to-idle; 0 on idle-to-active.
// R8: Slave-select enable 1 uses the select pin in slave role; 0 ignores it.
// R9: Polarity 1 idles the clock high; polarity 0 idles it low.
// R10: Master enable 1 makes the port master generating the clock; 0 slave.
// R11: Software clears the edge bit whenever framed mode is enabled.
// R12: Software clears slave-select enable whenever framed mode is enabled.
// R13: Software never sets both prescalers to one-to-one together.
// R14: Master clock equals system clock over product of both prescale ratios; the code divides by twice that product.
module spi_control_config (
    input  wire logic        clk_i,          // System clock
    input  wire logic        rst_i,          // Synchronous reset, high
    input  wire logic        wb_cyc_i,       // Wishbone cycle
    input  wire logic        wb_stb_i,       // Wishbone strobe
    input  wire logic        wb_we_i,        // Wishbone write enable
    input  wire logic [3:0]  wb_adr_i,       // Byte address
    input  wire logic [3:0]  wb_sel_i,       // Byte selects
    input  wire logic [31:0] wb_dat_i,       // Write data
    output logic      [31:0] wb_dat_o,       // Read data
    output logic             wb_ack_o,       // Acknowledge
    input  wire logic        sck_i,          // Serial clock pin in
    output logic             sck_o,          // Serial clock pin out
    output logic             sck_oe_n_o,     // Clock pin drive, low drives
    input  wire logic        sdi_i,          // Serial data in
    output logic             sdo_o,          // Serial data out
    output logic             sdo_oe_n_o,     // Data pin drive, low drives
    input  wire logic        ss_n_i          // Slave select, low active
);
    logic [15:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
    logic [15:0] tx_reg, tx_next, rx_reg, rx_next, shift_reg, shift_next;
    logic [15:0] in_reg, in_next;
    logic        ack_reg, ack_next, rdy_reg, rdy_next, busy_reg, busy_next;
    logic [4:0]  bits_reg, bits_next;
    logic [9:0]  div_reg, div_next;
    logic        sclk_reg, sclk_next, sdo_reg, sdo_next, start_reg, start_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [2:0]  sck_s, ss_s, sdi_s;

    // Ratio decode used for the primary prescaler
    function automatic logic [3:0] ppre_ratio(input logic [1:0] f);
        case (f)
            2'h0:    ppre_ratio = 4'h8;   // 64:1 expressed as 8*8 below
            2'h1:    ppre_ratio = 4'h4;
            2'h2:    ppre_ratio = 4'h2;
            default: ppre_ratio = 4'h1;
        endcase
    endfunction

    wire master   = ctrl1_reg[spi_cfg_pkg::master_bit];
    wire cpol     = ctrl1_reg[spi_cfg_pkg::cpol_bit];
    wire cke      = ctrl1_reg[spi_cfg_pkg::edge_bit];
    wire sample_phase = ctrl1_reg[spi_cfg_pkg::sample_phase_bit];
    wire word16   = ctrl1_reg[spi_cfg_pkg::word16_bit];
    wire ss_en    = ctrl1_reg[spi_cfg_pkg::ss_en_bit];
    wire clk_rel  = ctrl1_reg[spi_cfg_pkg::clk_rel_bit];
    wire dout_rel = ctrl1_reg[spi_cfg_pkg::dout_rel_bit];
    wire en       = ctrl2_reg[spi_cfg_pkg::port_en_bit];
    wire [2:0] spre = ctrl1_reg[spi_cfg_pkg::spre_lsb +: 3];
    wire [1:0] ppre = ctrl1_reg[spi_cfg_pkg::ppre_lsb +: 2];
    // Primary 64/16/4/1 = square of the decode; secondary 8..1 = 8 - field
    wire [3:0] pr   = ppre_ratio(ppre);
    wire [7:0] prim = 8'(pr * pr);
    wire [3:0] sec  = 4'h8 - {1'b0, spre};
    // Ten bits: the slowest setting, 64 x 8, does not fit in nine
    wire [9:0] half = 10'(prim * sec);                  // R14
    wire [4:0] nbits = word16 ? 5'h10 : 5'h08;          // R3 R4
    // Master edge decode: the leading edge leaves the idle level
    wire lead        = sclk_reg == cpol;
    wire last_bit    = bits_reg == 5'h1;
    wire first_half  = bits_reg == nbits;
    wire change_edge = cke ? ~lead : lead;              // R7
    // End of output time is the next changing edge; last bit ends on the closing edge
    wire take_bit    = sample_phase ? (cke ? ~lead : (lead ? ~first_half : last_bit))
                                    : ~change_edge;     // R5

    // Two-stage synchronisers; edges taken from stages two and three
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_s <= 3'h0;
            ss_s  <= 3'h7;
            sdi_s <= 3'h0;
        end else begin
            sck_s <= {sck_s[1:0], sck_i};
            ss_s  <= {ss_s[1:0], ss_n_i};
            sdi_s <= {sdi_s[1:0], sdi_i};
        end
    end
    wire s_rise = sck_s[1] & ~sck_s[2];
    wire s_fall = ~sck_s[1] & sck_s[2];
    // Leading edge leaves idle level; trailing returns to it
    wire s_lead  = cpol ? s_fall : s_rise;              // R9
    wire s_trail = cpol ? s_rise : s_fall;
    wire ss_ok   = ~ss_en | ~ss_s[1];                   // R8

    wire acc  = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr   = acc & wb_we_i;
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        rdy_next   = rdy_reg;
        start_next = 1'b0;
        ack_next   = acc;
        rdat_next  = 32'h0;
        if (wr) begin
            case (wb_adr_i)
                spi_cfg_pkg::ctrl_one_addr: ctrl1_next = ((wb_dat_i[15:0] & wmask) |
                    (ctrl1_reg & ~wmask)) & spi_cfg_pkg::ctrl_one_mask;
                spi_cfg_pkg::ctrl_two_addr: ctrl2_next = ((wb_dat_i[15:0] & wmask) |
                    (ctrl2_reg & ~wmask)) & spi_cfg_pkg::ctrl_two_mask;
                spi_cfg_pkg::data_addr: begin
                    tx_next    = (wb_dat_i[15:0] & wmask) | (tx_reg & ~wmask);
                    start_next = 1'b1;
                end
                default: ;
            endcase
        end else if (acc) begin
            case (wb_adr_i)
                spi_cfg_pkg::ctrl_one_addr: rdat_next = {16'h0, ctrl1_reg};
                spi_cfg_pkg::ctrl_two_addr: rdat_next = {16'h0, ctrl2_reg};
                spi_cfg_pkg::data_addr: begin
                    rdat_next = {16'h0, rx_reg};
                    rdy_next  = 1'b0;
                end
                spi_cfg_pkg::status_addr: rdat_next = {30'h0, busy_reg, rdy_reg};
                default: ;
            endcase
        end
        // Shift engine
        busy_next  = busy_reg;
        bits_next  = bits_reg;
        div_next   = div_reg;
        sclk_next  = sclk_reg;
        sdo_next   = sdo_reg;
        shift_next = shift_reg;
        in_next    = in_reg;
        if (!en) begin
            busy_next = 1'b0;
            sclk_next = cpol;                           // R9
        end else if (master) begin                      // R10
            if (clk_rel) begin                          // R1
                // Release cuts any frame short and parks the clock
                busy_next = 1'b0;
                sclk_next = cpol;
            end else if (!busy_reg) begin
                sclk_next = cpol;
                if (start_reg) begin
                    busy_next  = 1'b1;
                    bits_next  = nbits;
                    div_next   = half;
                    in_next    = 16'h0;
                    shift_next = word16 ? tx_reg : {tx_reg[7:0], 8'h0};
                    // First bit stands before the first edge in both edge modes
                    sdo_next   = word16 ? tx_reg[15] : tx_reg[7];
                end
            end else if (div_reg > 10'h1) begin
                div_next = div_reg - 10'h1;
            end else begin
                div_next  = half;
                sclk_next = ~sclk_reg;
                if (change_edge && !(cke ? last_bit : first_half)) begin  // R7
                    shift_next = {shift_reg[14:0], 1'b0};
                    sdo_next   = shift_reg[14];
                end
                if (take_bit)                           // R5
                    in_next = {in_reg[14:0], sdi_s[1]};
                if (!lead) begin
                    bits_next = bits_reg - 5'h1;
                    if (last_bit) begin
                        busy_next = 1'b0;
                        rx_next   = take_bit ? {in_reg[14:0], sdi_s[1]} : in_reg;
                        rdy_next  = 1'b1;
                    end
                end
            end
        end else begin
            // Slave role: sample on the edge opposite to the changing edge
            if (!busy_reg && start_reg) begin
                shift_next = word16 ? tx_reg : {tx_reg[7:0], 8'h0};
                sdo_next   = word16 ? tx_reg[15] : tx_reg[7];
                bits_next  = nbits;
                busy_next  = 1'b1;
            end else if (busy_reg && ss_ok) begin       // R8
                if (cke ? s_lead : s_trail)
                    shift_next = {shift_reg[14:0], sdi_s[1]};
                if (cke ? s_trail : s_lead) begin       // R7
                    sdo_next = shift_reg[15];
                end
                if (s_trail) begin
                    bits_next = bits_reg - 5'h1;
                    if (bits_reg == 5'h1) begin
                        busy_next = 1'b0;
                        rx_next   = cke ? shift_reg : {shift_reg[14:0], sdi_s[1]};
                        rdy_next  = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_reg <= spi_cfg_pkg::ctrl_one_reset;
            ctrl2_reg <= spi_cfg_pkg::ctrl_two_reset;
            tx_reg    <= 16'h0;
            rx_reg    <= 16'h0;
            shift_reg <= 16'h0;
            in_reg    <= 16'h0;
            ack_reg   <= 1'b0;
            rdy_reg   <= 1'b0;
            busy_reg  <= 1'b0;
            bits_reg  <= 5'h0;
            div_reg   <= 10'h0;
            sclk_reg  <= 1'b0;
            sdo_reg   <= 1'b0;
            start_reg <= 1'b0;
            rdat_reg  <= 32'h0;
        end else begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
            tx_reg    <= tx_next;
            rx_reg    <= rx_next;
            shift_reg <= shift_next;
            in_reg    <= in_next;
            ack_reg   <= ack_next;
            rdy_reg   <= rdy_next;
            busy_reg  <= busy_next;
            bits_reg  <= bits_next;
            div_reg   <= div_next;
            sclk_reg  <= sclk_next;
            sdo_reg   <= sdo_next;
            start_reg <= start_next;
            rdat_reg  <= rdat_next;
        end
    end

    assign wb_ack_o   = ack_reg;
    assign wb_dat_o   = rdat_reg;
    assign sck_o      = sclk_reg;
    // Clock pin driven only as an enabled master without release
    assign sck_oe_n_o = ~(en & master & ~clk_rel);      // R1 R10
    assign sdo_o      = sdo_reg;
    assign sdo_oe_n_o = ~(en & ~dout_rel);              // R2
endmodule

//--- design/spi_cfg_pkg.sv
package spi_cfg_pkg;
    // Register map (byte addresses on the bus, byte address = index * 4)
    localparam logic [3:0]  ctrl_one_addr   = 4'h0;
    localparam logic [3:0]  ctrl_two_addr   = 4'h4;
    localparam logic [3:0]  data_addr       = 4'h8;
    localparam logic [3:0]  status_addr     = 4'hc;
    // Control one field positions
    localparam int          clk_rel_bit     = 12;
    localparam int          dout_rel_bit    = 11;
    localparam int          word16_bit      = 10;
    localparam int          sample_phase_bit = 9;
    localparam int          edge_bit        = 8;
    localparam int          ss_en_bit       = 7;
    localparam int          cpol_bit        = 6;
    localparam int          master_bit      = 5;
    localparam int          spre_lsb        = 2;
    localparam int          ppre_lsb        = 0;
    localparam logic [15:0] ctrl_one_mask   = 16'h1fff;
    localparam logic [15:0] ctrl_one_reset  = 16'h0000;
    // Control two: bit 15 port enable, bit 1 framed mode enable
    localparam int          port_en_bit     = 15;
    localparam int          framed_bit      = 1;
    localparam logic [15:0] ctrl_two_mask   = 16'h8002;
    localparam logic [15:0] ctrl_two_reset  = 16'h0000;
    // Status: bit 1 busy, bit 0 receive data ready
    localparam int          busy_bit        = 1;
    localparam int          rx_ready_bit    = 0;
endpackage

//--- tb/spi_cfg_properties.sv
`timescale 1ns/1ps
module spi_cfg_properties (
    input  wire logic        clk_i,      // Clock
    input  wire logic        rst_i,      // Reset
    input  wire logic        wb_cyc_i,   // Cycle
    input  wire logic        wb_stb_i,   // Strobe
    input  wire logic        wb_we_i,    // Write
    input  wire logic [3:0]  wb_adr_i,   // Address
    input  wire logic [31:0] wb_dat_i,   // Write data
    input  wire logic        wb_ack_o,   // Ack
    input  wire logic        sck_o,      // Clock out
    input  wire logic        sck_oe_n_o, // Clock drive
    input  wire logic        sdo_oe_n_o  // Data drive
);
    logic [15:0] c1_reg, c1_next;
    logic        en_reg, en_next, wr, mst, crel, drel;
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign mst  = en_reg && c1_reg[spi_cfg_pkg::master_bit];
    assign crel = c1_reg[spi_cfg_pkg::clk_rel_bit];
    assign drel = c1_reg[spi_cfg_pkg::dout_rel_bit];
    // Shadow of the control bits, updated at the edge that takes the write
    always_comb begin
        c1_next = c1_reg;
        en_next = en_reg;
        if (wr && wb_adr_i == spi_cfg_pkg::ctrl_one_addr)
            c1_next = wb_dat_i[15:0] & spi_cfg_pkg::ctrl_one_mask;
        if (wr && wb_adr_i == spi_cfg_pkg::ctrl_two_addr)
            en_next = wb_dat_i[spi_cfg_pkg::port_en_bit];
    end
    always_ff @(posedge clk_i) begin
        c1_reg <= rst_i ? 16'h0000 : c1_next;
        en_reg <= rst_i ? 1'b0 : en_next;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_clk_release: assert property ((mst && crel)[*2] |-> sck_oe_n_o)
        else $error("clock pin driven while released");
    a_clk_frozen: assert property ((mst && crel)[*4] |-> $stable(sck_o))
        else $error("clock toggles while released");
    a_dout_release: assert property ((en_reg && drel)[*2] |-> sdo_oe_n_o)
        else $error("data pin driven while released");
    a_dout_drive: assert property ((en_reg && !drel)[*2] |-> !sdo_oe_n_o)
        else $error("data pin not driven");
    a_slave_no_clk: assert property ((!mst)[*2] |-> sck_oe_n_o)
        else $error("clock driven outside master role");
    a_master_clk: assert property ((mst && !crel)[*2] |-> !sck_oe_n_o)
        else $error("master not driving clock");
endmodule
bind spi_control_config spi_cfg_properties u_spi_cfg_properties (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .sdo_oe_n_o(sdo_oe_n_o));

//--- tb/spi_far_end.sv
`timescale 1ns/1ps
module spi_far_end (
    input  wire logic        sck_i,   // Clock line
    input  wire logic        cpol_i,  // Idle level
    input  wire logic        cke_i,   // Output edge select
    input  wire logic        mosi_i,  // Data from port
    input  wire logic [15:0] load_i,  // Word to return
    input  wire logic        start_i, // Frame begins
    output logic             miso_o,  // Data to port
    output logic      [15:0] got_o    // Word received
);
    logic [15:0] sh;
    int          n = 0;
    initial miso_o = 1'b0;
    always @(posedge start_i) begin
        sh = load_i;
        got_o = 16'h0000;
        n = 0;
        miso_o = load_i[15];
    end
    // No shift before the first sample, so the top bit is never skipped
    always @(sck_i) begin
        if ((sck_i != cpol_i) == cke_i) begin
            got_o = {got_o[14:0], mosi_i};
            n++;
        end else if (n > 0) begin
            sh = sh << 1;
            miso_o = sh[15];
        end
    end
endmodule

//--- tb/tb_spi_control_config.sv
`timescale 1ns/1ps
module tb_spi_control_config;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic        ack, sck_o, sck_oe_n, sdo, sdo_oe_n, sdi, sck_line, sdo_line, last_sck;
    logic [15:0] got, load = 16'h0, tx, rx, cfg = 16'h0;
    int          error_cnt = 0, checks = 0, ticks = 0, edges = 0, gap = 0, since = 0, e0, n;
    // Board pull-ups while a pin is released
    assign sck_line = sck_oe_n ? 1'b1 : sck_o;
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
    always #5 clk_i = ~clk_i;
    spi_control_config u_spi_control_config (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck_line), .sck_o(sck_o),
        .sck_oe_n_o(sck_oe_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .ss_n_i(1'b1));
    spi_far_end u_spi_far_end (.sck_i(sck_line), .cpol_i(cfg[6]), .cke_i(cfg[8]),
        .mosi_i(sdo_line), .load_i(load), .start_i(start), .miso_o(sdi), .got_o(got));
    task automatic wrap_up;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        ticks++;
        since++;
        last_sck <= sck_line;
        if (sck_line !== last_sck) begin
            edges++;
            gap = since;
            since = 0;
        end
        if (ticks > 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(15206));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, spi_cfg_pkg::ctrl_one_addr, 16'h0);
        chk(q, 32'h0);
        tx = 16'($urandom);
        bus(1, spi_cfg_pkg::ctrl_one_addr, tx);
        bus(0, spi_cfg_pkg::ctrl_one_addr, 16'h0);
        chk(q, {16'h0, tx & spi_cfg_pkg::ctrl_one_mask});
        bus(1, 4'h2, 16'hffff);
        bus(0, 4'h2, 16'h0);
        chk(q, 32'h0);
        bus(1, spi_cfg_pkg::ctrl_two_addr, 16'h8000);
        // Half period 4 x 2 clocks: 160 ns link clock
        for (int m = 0; m < 16; m++) begin
            cfg = 16'h003a | 16'(m[0]) << 10 | 16'(m[1]) << 6 | 16'(m[2]) << 8
                | 16'(m[3]) << 9;
            bus(1, spi_cfg_pkg::ctrl_one_addr, cfg);
            rx = 16'($urandom);
            tx = 16'($urandom);
            n = m[0] ? 16 : 8;
            load = m[0] ? rx : {rx[7:0], 8'h00};
            @(posedge clk_i);
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            e0 = edges;
            bus(1, spi_cfg_pkg::data_addr, tx);
            do bus(0, spi_cfg_pkg::status_addr, 16'h0); while (q[1] !== 1'b0);
            chk(edges - e0, 2 * n);
            chk(gap, 8);
            chk(sck_line, cfg[6]);
            bus(0, spi_cfg_pkg::data_addr, 16'h0);
            chk(q, m[0] ? rx : rx[7:0]);
            chk(got & (m[0] ? 16'hffff : 16'h00ff), m[0] ? tx : tx[7:0]);
            bus(0, spi_cfg_pkg::status_addr, 16'h0);
            chk(q[0], 1'b0);
        end
        bus(1, spi_cfg_pkg::ctrl_one_addr, 16'h183a);
        bus(1, spi_cfg_pkg::data_addr, 16'h00a5);
        bus(0, spi_cfg_pkg::status_addr, 16'h0);
        chk({sck_oe_n, sdo_oe_n, q[1]}, 3'b110);
        bus(1, spi_cfg_pkg::ctrl_one_addr, 16'h0000);
        bus(0, spi_cfg_pkg::status_addr, 16'h0);
        chk({sck_oe_n, sdo_oe_n}, 2'b10);
        wrap_up();
    end
endmodule
